/* File: logic/dpd_consts.svh */
`ifndef DPD_CONSTS_SVH
`define DPD_CONSTS_SVH
// wake address inside the 8KB window
`define DPD_WAKE_ADDR 13'h1FFF
// reads at the wake address needed to leave power-down
`define DPD_WAKE_READS 4'hC
// pin wake settle time in ns and its cycle count at 40 ns
`define DPD_PIN_WAKE_NS 700
`define DPD_CLK_NS 40
`define DPD_PIN_WAKE_CYC ((`DPD_PIN_WAKE_NS + `DPD_CLK_NS - 1) / `DPD_CLK_NS)
// control register sequence values
`define DPD_CMD_NORMAL 8'h05
`define DPD_CMD_RESET 8'h04
`define DPD_CMD_SLEEP 8'h02
// control and confirmation offsets
`define DPD_CTRL_ADDR 13'h100C
`define DPD_CONF_ADDR 13'h1072
// power-down pin control register offset and fields
`define DPD_PINCTL_ADDR 13'h107C
`define DPD_PINCTL_EN 0
`define DPD_PINCTL_POL 1
// generic register, for retention checks
`define DPD_TEST_ADDR 13'h1004
// boot block test pattern returned on boot block reads outside registers
`define DPD_BOOT_DATA 16'hA55A
`endif

/* File: logic/dpd_pkg.sv */
package dpd_pkg;
  typedef enum logic [1:0] {
    dpd_mode_reset,
    dpd_mode_normal,
    dpd_mode_sleep
  } dpd_mode_t;
  typedef enum logic [2:0] {
    dpd_h_idle,
    dpd_h_setup,
    dpd_h_strobe,
    dpd_h_done,
    dpd_h_wait
  } dpd_hstate_t;
endpackage : dpd_pkg

/* File: logic/dpd_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dpd_bus_if;
  logic [12:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic data_oe;
  logic chip_enable_n;
  logic write_strobe_n;
  logic output_strobe_n;
  logic address_valid_strobe_n;
  logic mux_bus;
  logic reset_input_n;
  logic power_down_pin;
  logic busy_n;
  logic [15:0] data_wire;
  assign data_wire = data_oe ? rdata : wdata;
  modport device (
    input addr, wdata, chip_enable_n, write_strobe_n, output_strobe_n,
    input address_valid_strobe_n, mux_bus, reset_input_n, power_down_pin,
    output rdata, data_oe, busy_n
  );
  modport host (
    output addr, wdata, chip_enable_n, write_strobe_n, output_strobe_n,
    output address_valid_strobe_n, mux_bus, reset_input_n, power_down_pin,
    input rdata, data_oe, busy_n
  );
endinterface : dpd_bus_if
`default_nettype wire

/* File: logic/dpd_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpd_consts.svh"
// host end: runs one bus cycle per request, drives reset and the pin
module dpd_host
  import dpd_pkg::*;
#(
  parameter int STROBE_CYC = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  dpd_bus_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic [12:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic mux_mode,
  input wire logic reset_req,
  input wire logic pin_toggle,
  output logic ack,
  output logic [15:0] rdata,
  output logic ready,
  output logic device_busy
);
  // the 4-bit strobe counter cannot serve more than 15 cycles
  if (STROBE_CYC < 1 || STROBE_CYC > 15) begin : g_bad_strobe
    $error("STROBE_CYC out of range");
  end
  localparam int WAKE_CYC = `DPD_PIN_WAKE_CYC;
  dpd_hstate_t state;
  logic [3:0] cnt;
  logic [5:0] wake_cnt;
  logic pin_level;
  logic [12:0] a_q;
  logic [15:0] d_q;
  logic wr_q;
  // bus cycle sequencer; strobes framed by chip enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= dpd_h_idle;
      cnt <= 4'h0;
      a_q <= 13'h0000;
      d_q <= 16'h0000;
      wr_q <= 1'b0;
      ack <= 1'b0;
      rdata <= 16'h0000;
      bus.chip_enable_n <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.output_strobe_n <= 1'b1;
      bus.address_valid_strobe_n <= 1'b1;
    end else begin
      ack <= 1'b0;
      case (state)
        dpd_h_idle: begin
          // new cycles wait out the pin wake time; ack still high
          // means the caller has not yet dropped the request just served
          if (req && !ack && wake_cnt == 6'h00 && !reset_req) begin
            a_q <= req_addr;
            d_q <= req_wdata;
            wr_q <= req_write;
            bus.chip_enable_n <= 1'b0;
            bus.address_valid_strobe_n <= !mux_mode;
            state <= dpd_h_setup;
          end
        end
        dpd_h_setup: begin
          bus.address_valid_strobe_n <= 1'b1;
          bus.write_strobe_n <= !wr_q;
          bus.output_strobe_n <= wr_q;
          cnt <= 4'(STROBE_CYC);
          state <= dpd_h_strobe;
        end
        dpd_h_strobe: begin
          if (cnt == 4'h1) begin
            rdata <= bus.rdata;
            bus.write_strobe_n <= 1'b1;
            bus.output_strobe_n <= 1'b1;
            state <= dpd_h_done;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        dpd_h_done: begin
          // chip enable negated after every cycle
          bus.chip_enable_n <= 1'b1;
          ack <= 1'b1;
          state <= dpd_h_idle;
        end
        default: state <= dpd_h_idle;
      endcase
    end
  end
  // pin toggling and the 700 ns wait after it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_level <= 1'b0;
      wake_cnt <= 6'h00;
    end else if (pin_toggle && state == dpd_h_idle) begin
      pin_level <= !pin_level;
      wake_cnt <= 6'(WAKE_CYC);
    end else if (wake_cnt != 6'h00) begin
      wake_cnt <= wake_cnt - 6'h01;
    end
  end
  // registered pins toward the device
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.addr <= 13'h0000;
      bus.wdata <= 16'h0000;
      bus.mux_bus <= 1'b0;
      bus.reset_input_n <= 1'b0;
      bus.power_down_pin <= 1'b0;
      ready <= 1'b0;
      device_busy <= 1'b1;
    end else begin
      bus.addr <= a_q;
      bus.wdata <= d_q;
      bus.mux_bus <= mux_mode;
      bus.reset_input_n <= !reset_req;
      bus.power_down_pin <= pin_level;
      device_busy <= !bus.busy_n;
      // boot fetch only once busy is negated
      ready <= bus.busy_n && !reset_req && wake_cnt == 6'h00;
    end
  end
endmodule : dpd_host
`default_nettype wire

/* File: logic/dpd_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpd_consts.svh"
module dpd_device
  import dpd_pkg::*;
#(
  parameter int STRETCH_CYC = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  dpd_bus_if.device bus,
  output logic asleep,
  output dpd_mode_t mode,
  output logic [7:0] test_reg
);
  // the 4-bit hold counter cannot reach a threshold above 15
  if (STRETCH_CYC < 2 || STRETCH_CYC > 15) begin : g_bad_stretch
    $error("STRETCH_CYC out of range");
  end
  // mode and command state
  dpd_mode_t prev_mode;
  logic sleep_armed;
  logic [7:0] ctrl_pending;
  logic [7:0] pin_ctl;
  logic [3:0] wake_cnt;
  logic [3:0] hold_cnt;
  logic [12:0] hold_addr;
  // previous-cycle copies of the strobes, pin and reset
  logic rd_q;
  logic wr_q;
  logic pin_q;
  logic rst_seen;
  // decoded view of the bus
  logic rd_now;
  logic wr_now;
  logic in_gate;
  logic [12:0] a_in;
  logic [15:0] d_in;
  logic pin_event;
  logic wake_read;
  logic wake_by_reads;
  logic wake_by_stretch;
  logic boot_addr;
  // inputs are gated off while asleep and chip enable negated;
  // zero stands in for a switched-off buffer, so a floating bus
  // can neither count cycles nor reach a register
  assign in_gate = asleep && bus.chip_enable_n;
  assign a_in = in_gate ? 13'h0000 : bus.addr;
  assign d_in = in_gate ? 16'h0000 : bus.wdata;
  // cycles need chip enable plus a strobe
  // a strobe without chip enable is noise, not a cycle
  assign rd_now = !bus.chip_enable_n && !bus.output_strobe_n && !in_gate;
  assign wr_now = !bus.chip_enable_n && !bus.write_strobe_n && !in_gate;
  // edge direction picked by the polarity field; a move away
  // from the set level is ignored, so leaving by the same edge
  // takes two toggles of the pin
  assign pin_event = pin_ctl[`DPD_PINCTL_EN] &&
    (bus.power_down_pin != pin_q) &&
    (bus.power_down_pin == pin_ctl[`DPD_PINCTL_POL]);
  // boot block sits in the first and last 2KB of the window
  assign boot_addr = a_in < 13'h0800 || a_in >= 13'h1800;
  // counted at the trailing edge of each read
  assign wake_read = rd_q && !rd_now && a_in == `DPD_WAKE_ADDR;
  // the twelfth counted read at the wake address
  assign wake_by_reads = wake_read && wake_cnt == `DPD_WAKE_READS - 4'h1;
  // a held boot read; never on the multiplexed bus
  assign wake_by_stretch = !bus.mux_bus && hold_cnt == 4'(STRETCH_CYC);
  // strobe edge tracking;
  // last-cycle copies give the leading and trailing strobe edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      pin_q <= 1'b0;
      rst_seen <= 1'b0;
    end else begin
      rd_q <= rd_now;
      wr_q <= wr_now;
      pin_q <= bus.power_down_pin;
      rst_seen <= !bus.reset_input_n;
    end
  end
  // stretched read timer; the count starts over if the address
  // moves, so only a read with a held address can wake the device by stretching
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt <= 4'h0;
      hold_addr <= 13'h0000;
    end else if (rd_now && asleep && boot_addr) begin
      hold_addr <= a_in;
      if (hold_cnt == 4'h0 || a_in == hold_addr) begin
        if (hold_cnt != 4'hF) begin
          hold_cnt <= hold_cnt + 4'h1;
        end
      end else begin
        hold_cnt <= 4'h1;
      end
    end else begin
      hold_cnt <= 4'h0;
    end
  end
  // mode machine;
  // the reset pin outranks all, its release cycle parks in reset mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= dpd_mode_reset;
      prev_mode <= dpd_mode_reset;
      asleep <= 1'b0;
      sleep_armed <= 1'b0;
      wake_cnt <= 4'h0;
    end else if (!bus.reset_input_n) begin
      asleep <= 1'b1;
      mode <= dpd_mode_sleep;
      prev_mode <= dpd_mode_reset;
      sleep_armed <= 1'b0;
      wake_cnt <= 4'h0;
    end else if (rst_seen) begin
      asleep <= 1'b0; // release lands in reset mode
      mode <= dpd_mode_reset;
    end else if (!asleep) begin
      // entry clears the read count so stale reads never help a wake
      if ((sleep_armed && bus.chip_enable_n) || pin_event) begin
        asleep <= 1'b1;
        prev_mode <= mode;
        mode <= dpd_mode_sleep;
        sleep_armed <= 1'b0;
        wake_cnt <= 4'h0;
      end else if (wr_q && !wr_now && a_in == `DPD_CONF_ADDR) begin
        if (ctrl_pending == `DPD_CMD_SLEEP && mode == dpd_mode_normal) begin
          sleep_armed <= 1'b1;
        end else if (ctrl_pending == `DPD_CMD_NORMAL) begin
          mode <= dpd_mode_normal;
        end else if (ctrl_pending == `DPD_CMD_RESET) begin
          mode <= dpd_mode_reset;
        end
      end
    end else if (pin_event || wake_by_reads || wake_by_stretch) begin
      asleep <= 1'b0;
      mode <= prev_mode;
      wake_cnt <= 4'h0;
    end else if (wake_read) begin
      wake_cnt <= wake_cnt + 4'h1;
    end
  end
  // register writes; contents never cleared by sleep
  // writes land on the leading strobe edge, once per cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_pending <= 8'h00;
      pin_ctl <= 8'h00;
      test_reg <= 8'h00;
    end else if (wr_now && !wr_q && !asleep) begin
      if (a_in == `DPD_CTRL_ADDR) begin
        ctrl_pending <= d_in[7:0];
        // reset mode keeps only the control pair writable
      end else if (mode == dpd_mode_normal) begin
        if (a_in == `DPD_PINCTL_ADDR) begin
          pin_ctl <= d_in[7:0];
        end else if (a_in == `DPD_TEST_ADDR) begin
          test_reg <= d_in[7:0];
        end
      end
    end
  end
  // read data and bus drive; data leads the host's capture by a cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.rdata <= 16'h0000;
      bus.data_oe <= 1'b0;
      bus.busy_n <= 1'b0;
    end else begin
      // busy spans reset and its release cycle so boot fetches wait
      bus.busy_n <= bus.reset_input_n && !rst_seen;
      // no drive while asleep, in reset or on a pin edge; a
      // stretched read starts to drive once its wake has landed
      bus.data_oe <= rd_now && !asleep && bus.reset_input_n &&
        !pin_event;
      if (mode == dpd_mode_reset && !boot_addr) begin
        bus.rdata <= 16'h0000;
      end else if (a_in == `DPD_CTRL_ADDR) begin
        bus.rdata <= {14'h0000, mode};
      end else if (a_in == `DPD_PINCTL_ADDR) begin
        bus.rdata <= {8'h00, pin_ctl};
      end else if (a_in == `DPD_TEST_ADDR) begin
        bus.rdata <= {8'h00, test_reg};
      end else if (boot_addr) begin
        bus.rdata <= `DPD_BOOT_DATA; // correct data
      end else begin
        bus.rdata <= 16'h0000;
      end
    end
  end
endmodule : dpd_device
`default_nettype wire

/* File: tb/dpd_bus_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the shared bus and the device sleep flag
module dpd_bus_checker
  import dpd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic data_oe,
  input wire logic chip_enable_n,
  input wire logic reset_input_n,
  input wire logic power_down_pin,
  input wire logic busy_n,
  input wire logic asleep,
  input wire dpd_mode_t mode,
  input wire logic [7:0] test_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [4:0] pin_age;
  // cycles since the pin moved; saturates so old moves never matter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_age <= 5'h1F;
    end else if ($changed(power_down_pin)) begin
      pin_age <= 5'h00;
    end else if (pin_age != 5'h1F) begin
      pin_age <= pin_age + 5'h01;
    end
  end
  AST_OE_ASLEEP: assert property (asleep |-> !data_oe)
    else $error("data driven while asleep");
  AST_OE_CE: assert property (data_oe |-> !chip_enable_n)
    else $error("data driven without chip enable");
  AST_RST_SLEEP: assert property ((rst_b && !reset_input_n) [*2] |->
    asleep)
    else $error("awake while reset held");
  AST_RST_MODE: assert property ($rose(reset_input_n) |->
    ##[1:2] (mode == dpd_mode_reset && !asleep))
    else $error("reset release did not give reset mode");
  AST_BUSY_HELD: assert property (!reset_input_n |=> !busy_n)
    else $error("busy not shown during reset");
  AST_BUSY_DONE: assert property (reset_input_n [*3] |-> busy_n)
    else $error("busy stuck after reset");
  AST_PIN_WAIT: assert property ($fell(chip_enable_n) |->
    pin_age >= 5'h11)
    else $error("bus cycle too soon after pin move");
  AST_SLEEP_HOLD: assert property (asleep |=> $stable(test_reg))
    else $error("register changed while asleep");
endmodule : dpd_bus_checker
`default_nettype wire

/* File: tb/deep_power_down_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpd_consts.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  mismatches++; $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); \
  end end
module deep_power_down_control_tb
  import dpd_pkg::*;
;
  logic clk, rst_b, req, req_write, reset_req, pin_toggle, mux;
  logic [12:0] req_addr;
  logic [15:0] req_wdata, rdata, rd;
  logic ack, ready, device_busy, asleep;
  logic [7:0] test_reg, v;
  dpd_mode_t mode;
  int mismatches, n_compared, cyc, i;
  dpd_bus_if bus();
  dpd_host i_dpd_host (.clk(clk), .rst_b(rst_b), .bus(bus), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .mux_mode(mux), .reset_req(reset_req), .pin_toggle(pin_toggle),
    .ack(ack), .rdata(rdata), .ready(ready), .device_busy(device_busy));
  dpd_device i_dpd_device (.clk(clk), .rst_b(rst_b), .bus(bus),
    .asleep(asleep), .mode(mode), .test_reg(test_reg));
  dpd_bus_checker i_chk (.clk(clk), .rst_b(rst_b), .data_oe(bus.data_oe),
    .chip_enable_n(bus.chip_enable_n), .reset_input_n(bus.reset_input_n),
    .power_down_pin(bus.power_down_pin), .busy_n(bus.busy_n),
    .asleep(asleep), .mode(mode), .test_reg(test_reg));
  // registers read as zero in reset mode
  function automatic logic [7:0] reg_view(input logic rmode,
                                          input logic [7:0] val);
    return rmode ? 8'h00 : val;
  endfunction : reg_view
  // one bus cycle; sampling on the falling edge avoids edge races
  task automatic op(input logic w, input logic [12:0] a,
                    input logic [15:0] d);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (ready !== 1'b1) mismatches++;
    @(posedge clk);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) mismatches++;
    rd = rdata;
    @(posedge clk);
    req <= 1'b0;
  endtask : op
  task automatic pin_pulse();
    @(posedge clk);
    pin_toggle <= 1'b1;
    @(posedge clk);
    pin_toggle <= 1'b0;
  endtask : pin_pulse
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles expected
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    rst_b = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = 13'h0000;
    req_wdata = 16'h0000;
    reset_req = 1'b0;
    pin_toggle = 1'b0;
    mux = 1'b0;
    void'($urandom(94));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    v = 8'($urandom_range(1, 255));
    op(1'b0, `DPD_TEST_ADDR, 16'h0000);
    `CHK(mode, dpd_mode_reset)
    `CHK(rd[7:0], reg_view(1'b1, v))
    op(1'b1, `DPD_TEST_ADDR, {8'h00, v});
    `CHK(test_reg, 8'h00)
    $display("test reset_mode done");
    op(1'b1, `DPD_CTRL_ADDR, {8'h00, `DPD_CMD_NORMAL});
    op(1'b1, `DPD_CONF_ADDR, 16'($urandom));
    `CHK(mode, dpd_mode_normal)
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom);
      op(1'b1, `DPD_TEST_ADDR, {8'h00, v});
      op(1'b0, `DPD_TEST_ADDR, 16'h0000);
      `CHK(rd[7:0], reg_view(1'b0, v))
    end
    $display("test normal_rw done");
    op(1'b1, `DPD_CTRL_ADDR, {8'h00, `DPD_CMD_SLEEP});
    op(1'b1, `DPD_CONF_ADDR, 16'($urandom));
    repeat (2) @(negedge clk);
    `CHK(asleep, 1'b1)
    op(1'b1, `DPD_TEST_ADDR, {8'h00, ~v});
    `CHK(test_reg, v)
    for (i = 0; i < 11; i++) op(1'b0, `DPD_WAKE_ADDR, 16'h0000);
    `CHK(asleep, 1'b1)
    op(1'b0, `DPD_WAKE_ADDR, 16'h0000);
    repeat (2) @(negedge clk);
    `CHK(asleep, 1'b0)
    `CHK(mode, dpd_mode_normal)
    `CHK(test_reg, v)
    $display("test read_wake done");
    op(1'b1, `DPD_PINCTL_ADDR, 16'h0003);
    pin_pulse();
    repeat (3) @(negedge clk);
    `CHK(asleep, 1'b1)
    // the pin falls back first; only a rise to the set level wakes
    pin_pulse();
    pin_pulse();
    @(negedge clk);
    `CHK(ready, 1'b0)
    op(1'b0, `DPD_TEST_ADDR, 16'h0000);
    `CHK(asleep, 1'b0)
    `CHK(rd[7:0], v)
    $display("test pin_wake done");
    @(posedge clk);
    reset_req <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK(asleep, 1'b1)
    `CHK(device_busy, 1'b1)
    @(posedge clk);
    reset_req <= 1'b0;
    op(1'b0, `DPD_TEST_ADDR, 16'h0000);
    `CHK(mode, dpd_mode_reset)
    `CHK(rd[7:0], 8'h00)
    $display("test reset_sleep done");
    // multiplexed bus: same sleep entry and read wake
    @(posedge clk);
    mux <= 1'b1;
    op(1'b1, `DPD_CTRL_ADDR, {8'h00, `DPD_CMD_NORMAL});
    op(1'b1, `DPD_CONF_ADDR, 16'($urandom));
    op(1'b1, `DPD_CTRL_ADDR, {8'h00, `DPD_CMD_SLEEP});
    op(1'b1, `DPD_CONF_ADDR, 16'($urandom));
    repeat (2) @(negedge clk);
    `CHK(asleep, 1'b1)
    for (i = 0; i < 12; i++) op(1'b0, `DPD_WAKE_ADDR, 16'h0000);
    repeat (2) @(negedge clk);
    `CHK(asleep, 1'b0)
    `CHK(mode, dpd_mode_normal)
    $display("test mux_wake done");
    give_verdict();
  end
endmodule : deep_power_down_control_tb
`default_nettype wire
